// [design/dcf_fifo.sv]
// dcf_fifo: deep FIFO with standard or fall-through timing, five status
// flags, programmable almost-empty/almost-full offsets and an APB port.
// assumes write, read and serial-load controls come from logic on REF_CLK;
// the two strap pins are asynchronous and are synchronised.
//
// Function
// - mode strap latched at reset, held
// - standard mode: every word needs read enable
// - fall-through: first word appears after three edges
// - words stored only with write enable low
// - standard: empty flag rises after first write
// - standard: almost-empty rises at n+1 words
// - standard: half-full falls at half plus one
// - standard: almost-full falls at depth minus m
// - standard: full flag at depth, writes blocked
// - standard: reads release full, almost-full, half, almost-empty
// - empty flag at last read; empty ignores reads
// - standard: empty and full flags twice registered
// - fall-through: output-ready low when word presented
// - fall-through: almost-empty at n+2 words
// - fall-through: half-full falls at half plus two
// - fall-through: almost-full falls at depth+1-m
// - fall-through: input-ready high at depth+1 words
// - fall-through: read releases input-ready; empty raises output-ready
// - output-ready three stages, input-ready two stages
// - load strap picks serial/parallel and default offsets
// - offsets read back only over parallel bus
// - offsets reprogrammable any time after reset
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module dcf_fifo #(
    parameter int DEPTH = dcf_pkg::DEPTH_SHORT
) (
    input  wire logic                        REF_CLK,             // 20 MHz clock
    input  wire logic                        SRST,                // sync reset
    input  wire logic                        PSEL,                // apb select
    input  wire logic                        PENABLE,             // apb access phase
    input  wire logic                        PWRITE,              // apb direction
    input  wire logic [dcf_pkg::APB_AW-1:0]  PADDR,               // apb byte address
    input  wire logic [dcf_pkg::APB_DW-1:0]  PWDATA,              // apb write data
    output logic      [dcf_pkg::APB_DW-1:0]  PRDATA,              // apb read data
    output logic                             PREADY,              // apb ready
    output logic                             PSLVERR,             // unmapped address
    input  wire logic                        WR_EN_N,             // write enable
    input  wire logic [dcf_pkg::DATA_W-1:0]  DATA_IN,             // write word
    input  wire logic                        RD_EN_N,             // read enable
    output logic      [dcf_pkg::DATA_W-1:0]  DATA_OUT,            // read word
    input  wire logic                        FALL_THROUGH_SELECT, // mode strap
    input  wire logic                        LOAD_SELECT_N,       // load strap
    input  wire logic                        SERIAL_IN,           // serial offset bit
    input  wire logic                        SERIAL_EN_N,         // serial shift enable
    output logic                             EMPTY_FLAG_N,        // empty / output-ready
    output logic                             FULL_FLAG_N,         // full / input-ready
    output logic                             ALMOST_EMPTY_N,      // almost-empty
    output logic                             HALF_FULL_N,         // half-full
    output logic                             ALMOST_FULL_N        // almost-full
);
    import dcf_pkg::*;

    localparam int AW  = $clog2(DEPTH);
    localparam int OW  = AW;
    localparam int WW  = AW + 2;
    localparam int SW  = 2 * OW;
    localparam int SCW = $clog2(SW);

    // pointer, shift and flag widths only serve these two depths
    if (DEPTH != DEPTH_SHORT && DEPTH != DEPTH_DEEP) begin : g_depth_check
        $error("DEPTH must be 8192 or 16384");
    end

    function automatic logic [WW-1:0] widen(input logic [OW-1:0] v);
        widen = WW'(v);
    endfunction

    // ------------------------------------------------------------
    // strap capture
    // ------------------------------------------------------------
    logic fts_s1_q, fts_s2_q, lds_s1_q, lds_s2_q;
    logic fwft_q, load_ser_q;
    logic [1:0] age_q;

    always_ff @(posedge REF_CLK) begin
        fts_s1_q <= FALL_THROUGH_SELECT;
        fts_s2_q <= fts_s1_q;
        lds_s1_q <= LOAD_SELECT_N;
        lds_s2_q <= lds_s1_q;
    end

    // straps only count while reset is held; later pin changes are ignored
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            fwft_q     <= fts_s2_q;
            load_ser_q <= lds_s2_q;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            age_q <= 2'h0;
        end else if (age_q != RST_SETTLED) begin
            age_q <= age_q + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // storage and pointers
    // ------------------------------------------------------------
    logic [DATA_W-1:0] mem_q [DEPTH];
    logic [AW-1:0]     wp_q, rp_q;
    logic [AW:0]       cnt_q;
    logic              ov_q;
    logic [1:0]        ft_cnt_q;
    logic [DATA_W-1:0] dout_q;
    logic              mem_empty, mem_full, do_wr, do_rd, take, load, pop;
    logic [WW-1:0]     tot;

    assign mem_empty = (cnt_q == '0);
    assign mem_full  = (cnt_q == (AW+1)'(DEPTH));
    assign do_wr     = !WR_EN_N && !mem_full;
    assign do_rd     = !fwft_q && !RD_EN_N && !mem_empty;
    assign take      = fwft_q && ov_q && !RD_EN_N;
    assign load      = fwft_q && !mem_empty &&
                       ((ov_q && !RD_EN_N) || (!ov_q && ft_cnt_q == FT_LAST_EDGE));
    assign pop       = do_rd || load;
    assign tot       = WW'(cnt_q) + WW'(ov_q);

    always_ff @(posedge REF_CLK) begin
        if (do_wr) begin
            mem_q[wp_q] <= DATA_IN;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (do_wr) begin
                wp_q <= wp_q + AW'(1);
            end
            if (pop) begin
                rp_q <= rp_q + AW'(1);
            end
            cnt_q <= cnt_q + (AW+1)'(do_wr) - (AW+1)'(pop);
        end
    end

    // output register; in fall-through it is the extra word of capacity
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            ov_q     <= 1'b0;
            ft_cnt_q <= 2'h0;
            dout_q   <= '0;
        end else begin
            if (pop) begin
                dout_q <= mem_q[rp_q];
            end
            if (load) begin
                ov_q <= 1'b1;
            end else if (take) begin
                ov_q <= 1'b0;
            end
            if (fwft_q && !ov_q && !mem_empty && ft_cnt_q != FT_LAST_EDGE) begin
                ft_cnt_q <= ft_cnt_q + 2'h1;
            end else begin
                ft_cnt_q <= 2'h0;
            end
        end
    end

    // ------------------------------------------------------------
    // offsets: parallel over apb, serial shift when strapped
    // ------------------------------------------------------------
    logic [OW-1:0]  e_off_q, f_off_q;
    logic [SW-1:0]  sh_q, sh_d;
    logic [SCW-1:0] sh_cnt_q;
    logic           sh_go, sh_done, apb_wr, apb_rd;
    logic [OW-1:0]  def_off;

    assign def_off = load_ser_q ? OW'(OFF_DEF_SERIAL) : OW'(OFF_DEF_PARAL);
    assign sh_go   = load_ser_q && !SERIAL_EN_N;
    assign sh_d    = {SERIAL_IN, sh_q[SW-1:1]};
    assign sh_done = sh_go && (sh_cnt_q == SCW'(SW - 1));
    assign apb_wr  = PSEL && PENABLE && PREADY && PWRITE;
    assign apb_rd  = PSEL && PENABLE && !PREADY;

    // a frame cut short leaves both offsets untouched until all bits are in
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            sh_q     <= '0;
            sh_cnt_q <= '0;
        end else if (sh_go) begin
            sh_q     <= sh_d;
            sh_cnt_q <= sh_done ? '0 : sh_cnt_q + SCW'(1);
        end
    end

    // reset branch reads a flop on the same clock; reset is synchronous
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            e_off_q <= lds_s2_q ? OW'(OFF_DEF_SERIAL) : OW'(OFF_DEF_PARAL);
            f_off_q <= lds_s2_q ? OW'(OFF_DEF_SERIAL) : OW'(OFF_DEF_PARAL);
        end else if (apb_wr && PADDR == ADDR_EMPTY_OFF) begin
            e_off_q <= PWDATA[OW-1:0];
        end else if (apb_wr && PADDR == ADDR_FULL_OFF) begin
            f_off_q <= PWDATA[OW-1:0];
        end else if (sh_done) begin
            e_off_q <= sh_d[OW-1:0];
            f_off_q <= sh_d[SW-1:OW];
        end
    end

    // ------------------------------------------------------------
    // flag thresholds
    // ------------------------------------------------------------
    logic ef_raw, ff_raw, ae_raw, hf_raw, af_raw;
    logic [WW-1:0] half_thr, af_thr, ae_thr;

    always_comb begin
        half_thr = WW'(DEPTH / 2) + WW'(1) + WW'(fwft_q);
        af_thr   = WW'(DEPTH) - widen(f_off_q) + WW'(fwft_q);
        ae_thr   = widen(e_off_q) + WW'(1) + WW'(fwft_q);
        ae_raw   = (tot >= ae_thr);
        hf_raw   = !(tot >= half_thr);
        af_raw   = !(tot >= af_thr);
        if (fwft_q) begin
            ef_raw = !ov_q;
            ff_raw = mem_full && ov_q;
        end else begin
            ef_raw = !mem_empty;
            ff_raw = !mem_full;
        end
    end

    // ------------------------------------------------------------
    // flag pipelines
    // ------------------------------------------------------------
    logic ef_s1_q, ef_s2_q, ff_s1_q;

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            ef_s1_q        <= 1'b0;
            ef_s2_q        <= 1'b0;
            ff_s1_q        <= 1'b1;
            EMPTY_FLAG_N   <= 1'b0;
            FULL_FLAG_N    <= 1'b1;
            ALMOST_EMPTY_N <= 1'b0;
            HALF_FULL_N    <= 1'b1;
            ALMOST_FULL_N  <= 1'b1;
        end else begin
            ef_s1_q        <= ef_raw;
            ef_s2_q        <= ef_s1_q;
            ff_s1_q        <= ff_raw;
            EMPTY_FLAG_N   <= fwft_q ? ef_s2_q : ef_s1_q;
            FULL_FLAG_N    <= ff_s1_q;
            ALMOST_EMPTY_N <= ae_raw;
            HALF_FULL_N    <= hf_raw;
            ALMOST_FULL_N  <= af_raw;
        end
    end

    assign DATA_OUT = dout_q;

    // ------------------------------------------------------------
    // apb slave: one wait state, registered answer
    // ------------------------------------------------------------
    // unmapped reads answer with an error; status and level ignore writes
    logic [APB_DW-1:0] rd_mux;
    logic              rd_err;

    always_comb begin
        rd_mux = '0;
        rd_err = 1'b0;
        if (PADDR == ADDR_EMPTY_OFF) begin
            rd_mux[OW-1:0] = e_off_q;
        end else if (PADDR == ADDR_FULL_OFF) begin
            rd_mux[OW-1:0] = f_off_q;
        end else if (PADDR == ADDR_STATUS) begin
            rd_mux[ST_FWFT]   = fwft_q;
            rd_mux[ST_SERIAL] = load_ser_q;
            rd_mux[ST_EMPTY]  = EMPTY_FLAG_N;
            rd_mux[ST_FULL]   = FULL_FLAG_N;
            rd_mux[ST_AEMPTY] = ALMOST_EMPTY_N;
            rd_mux[ST_HALF]   = HALF_FULL_N;
            rd_mux[ST_AFULL]  = ALMOST_FULL_N;
        end else if (PADDR == ADDR_LEVEL) begin
            rd_mux[WW-1:0] = tot;
        end else begin
            rd_err = 1'b1;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            PREADY  <= 1'b0;
            PRDATA  <= '0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY  <= apb_rd;
            PSLVERR <= apb_rd && rd_err;
            if (apb_rd && !PWRITE) begin
                PRDATA <= rd_mux;
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SRST);

    sequence s_ft_wait;
        (fwft_q && !ov_q && !mem_empty) [*3];
    endsequence

    property p_mode_hold;
        $past(!SRST) |-> $stable(fwft_q) && $stable(load_ser_q);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed");

    property p_std_no_spont;
        !fwft_q && $changed(dout_q) |-> $past(!RD_EN_N) && $past(cnt_q) != '0;
    endproperty
    a_std_no_spont: assert property (p_std_no_spont) else $error("unrequested word");

    property p_ft_three;
        s_ft_wait |=> ov_q && dout_q == $past(mem_q[rp_q]);
    endproperty
    a_ft_three: assert property (p_ft_three) else $error("fall-through late");

    property p_no_wr;
        WR_EN_N && RD_EN_N |=> cnt_q == $past(cnt_q) - (AW+1)'($past(load));
    endproperty
    a_no_wr: assert property (p_no_wr) else $error("word stored without enable");

    property p_full_block;
        mem_full && RD_EN_N |=> cnt_q == $past(cnt_q) - (AW+1)'($past(load));
    endproperty
    a_full_block: assert property (p_full_block) else $error("write into full");

    property p_empty_ignore;
        !fwft_q && mem_empty && WR_EN_N |=> $stable(dout_q) && $stable(rp_q);
    endproperty
    a_empty_ignore: assert property (p_empty_ignore) else $error("read while empty");

    property p_std_ef_two;
        !fwft_q && age_q == RST_SETTLED |-> EMPTY_FLAG_N == $past(ef_raw, 2);
    endproperty
    a_std_ef_two: assert property (p_std_ef_two) else $error("empty flag depth");

    property p_ft_or_three;
        fwft_q && age_q == RST_SETTLED |-> EMPTY_FLAG_N == $past(!ov_q, 3);
    endproperty
    a_ft_or_three: assert property (p_ft_or_three) else $error("ready flag depth");

    property p_defaults;
        $past(SRST) |-> e_off_q == def_off && f_off_q == def_off;
    endproperty
    a_defaults: assert property (p_defaults) else $error("bad default offset");

    property p_half;
        age_q == RST_SETTLED && tot >= half_thr |=> !HALF_FULL_N;
    endproperty
    a_half: assert property (p_half) else $error("half flag wrong");

    property p_ft_take;
        fwft_q && ov_q && !RD_EN_N && mem_empty |=> !ov_q;
    endproperty
    a_ft_take: assert property (p_ft_take) else $error("last word not released");

endmodule : dcf_fifo

// [design/dcf_pkg.sv]
// dcf_pkg: constants shared by the dual-mode FIFO core and its bench.
// assumes a 32-bit APB slave with word-aligned registers.
package dcf_pkg;

    // ------------------------------------------------------------
    // geometry and bus widths
    // ------------------------------------------------------------
    localparam int DATA_W      = 18;
    localparam int DEPTH_SHORT = 8192;
    localparam int DEPTH_DEEP  = 16384;
    localparam int APB_AW      = 12;
    localparam int APB_DW      = 32;

    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_EMPTY_OFF = 12'h000;
    localparam logic [11:0] ADDR_FULL_OFF  = 12'h004;
    localparam logic [11:0] ADDR_STATUS    = 12'h008;
    localparam logic [11:0] ADDR_LEVEL     = 12'h00C;

    // ------------------------------------------------------------
    // status register bit positions
    // ------------------------------------------------------------
    localparam int ST_FWFT   = 0;
    localparam int ST_SERIAL = 1;
    localparam int ST_EMPTY  = 2;
    localparam int ST_FULL   = 3;
    localparam int ST_AEMPTY = 4;
    localparam int ST_HALF   = 5;
    localparam int ST_AFULL  = 6;

    // ------------------------------------------------------------
    // reset values and cycle counts
    // ------------------------------------------------------------
    localparam logic [15:0] OFF_DEF_SERIAL = 16'h03FF;
    localparam logic [15:0] OFF_DEF_PARAL  = 16'h007F;
    localparam logic [1:0]  FT_LAST_EDGE   = 2'h2;   // third read edge
    localparam logic [1:0]  RST_SETTLED    = 2'h3;

endpackage : dcf_pkg

// [tb/dcf_far_end.sv]
// dcf_far_end: writer and reader logic facing the FIFO data ports.
// assumes its tasks are called just after a rising CLK edge.
`timescale 1ns/1ps
module dcf_far_end (
    input  wire logic                       CLK,     // shared clock
    output logic                            WR_EN_N, // write enable
    output logic [dcf_pkg::DATA_W-1:0]      DATA_IN, // write word
    output logic                            RD_EN_N  // read enable
);
    import dcf_pkg::*;
    logic [DATA_W-1:0] seq = 18'h2A5C3;
    initial begin
        WR_EN_N <= 1'b1;
        RD_EN_N <= 1'b1;
        DATA_IN <= 18'h15A3C;
    end
    // --------------------------------------------------------
    // writer: back-to-back words, running pattern
    // --------------------------------------------------------
    task automatic push(input int n);
        repeat (n) begin
            WR_EN_N <= 1'b0;
            DATA_IN <= seq;
            seq = seq + 18'h1;
            @(posedge CLK);
        end
        WR_EN_N <= 1'b1;
        DATA_IN <= ~DATA_IN; // released bus shows no stale word
    endtask
    // --------------------------------------------------------
    // reader: one request per word, idle cycle between
    // --------------------------------------------------------
    task automatic pull(input int n);
        repeat (n) begin
            RD_EN_N <= 1'b0;
            @(posedge CLK);
            RD_EN_N <= 1'b1;
            @(posedge CLK);
        end
    endtask
endmodule // dcf_far_end

// [tb/dcf_fifo_tb_top.sv]
// dcf_fifo_tb_top: self-checking bench, both timing modes, DEPTH 8192.
// assumes dcf_far_end drives the data ports; APB tasks drive registers.
`timescale 1ns/1ps
module dcf_fifo_tb_top;
    import dcf_pkg::*;
    localparam int          LIMIT = 70000;
    localparam logic [17:0] W0    = 18'h2A5C3;
    logic              clk = 1'b0;
    logic              srst = 1'b1;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [11:0]       paddr = 12'h000;
    logic [31:0]       pwdata = 32'h0;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic [17:0]       data_in;
    logic [17:0]       data_out;
    logic [17:0]       w;
    logic              wr_en_n;
    logic              rd_en_n;
    logic              ft_sel = 1'b0;
    logic              ld_sel_n = 1'b0;
    logic              ser_in = 1'b0;
    logic              ser_en_n = 1'b1;
    logic              ef_n, ff_n, ae_n, hf_n, af_n;
    logic [4:0]        flg;
    logic [31:0]       rd;
    logic [31:0]       err;
    int                miscompares = 0;
    int                checked = 0;
    int                cycles = 0;
    int                lvl = 0;
    int                std_l [8] = '{1, 10, 11, 4096, 4097, 8171, 8172, 8192};
    logic [4:0]        std_f [8] = '{5'h1D, 5'h1D, 5'h1F, 5'h1F, 5'h1B, 5'h1B, 5'h13, 5'h03};
    int                ft_l  [8] = '{1, 1024, 1025, 4097, 4098, 7169, 7170, 8193};
    logic [4:0]        ft_f  [8] = '{5'h0C, 5'h0C, 5'h0E, 5'h0E, 5'h0A, 5'h0A, 5'h02, 5'h12};
    assign flg = {ff_n, af_n, hf_n, ae_n, ef_n};

    always #25 clk = ~clk;

    dcf_fifo #(.DEPTH(DEPTH_SHORT)) i_dut (
        .REF_CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .WR_EN_N(wr_en_n), .DATA_IN(data_in), .RD_EN_N(rd_en_n),
        .DATA_OUT(data_out), .FALL_THROUGH_SELECT(ft_sel), .LOAD_SELECT_N(ld_sel_n),
        .SERIAL_IN(ser_in), .SERIAL_EN_N(ser_en_n), .EMPTY_FLAG_N(ef_n), .FULL_FLAG_N(ff_n),
        .ALMOST_EMPTY_N(ae_n), .HALF_FULL_N(hf_n), .ALMOST_FULL_N(af_n));

    dcf_far_end i_far (.CLK(clk), .WR_EN_N(wr_en_n), .DATA_IN(data_in), .RD_EN_N(rd_en_n));

    // --------------------------------------------------------
    // shared tasks
    // --------------------------------------------------------
    task automatic end_sim();
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // extra idle edge at the end so no signal is assigned twice in one step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = {31'h0, pslverr};
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic do_reset(input logic ft, input logic ld);
        ft_sel <= ft;
        ld_sel_n <= ld;
        srst <= 1'b1;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        repeat (6) @(posedge clk);
        lvl = 0;
    endtask

    // serial frame: empty offset lsb first, full offset msb last
    task automatic shift_bits(input logic [25:0] v, input int lo, input int hi);
        for (int i = lo; i <= hi; i++) begin
            ser_en_n <= 1'b0;
            ser_in <= v[i];
            @(posedge clk);
        end
        ser_en_n <= 1'b1;
        @(posedge clk);
    endtask

    // flags are looked at only after they have had time to settle
    task automatic move_to(input int l);
        if (l > lvl) i_far.push(l - lvl);
        else if (l < lvl) i_far.pull(lvl - l);
        lvl = l;
        repeat (5) @(posedge clk);
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            miscompares++;
            end_sim();
        end
    end

    // --------------------------------------------------------
    // main sequence
    // --------------------------------------------------------
    initial begin
        do_reset(1'b0, 1'b0);
        apb(1'b0, ADDR_EMPTY_OFF, 32'h0);
        chk(rd, 32'h7F);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd & 32'h7F, 32'h68);
        apb(1'b0, 12'h010, 32'h0);
        chk(err, 32'h1);
        apb(1'b1, ADDR_EMPTY_OFF, 32'hA);
        apb(1'b1, ADDR_FULL_OFF, 32'h14);
        apb(1'b0, ADDR_FULL_OFF, 32'h0);
        chk(rd, 32'h14);
        for (int i = 0; i < 8; i++) begin
            move_to(std_l[i]);
            chk(flg, std_f[i]);
        end
        chk(data_out, 32'h0);
        i_far.push(1);
        apb(1'b0, ADDR_LEVEL, 32'h0);
        chk(rd, 32'd8192);
        move_to(8191);
        chk(data_out, W0);
        chk(flg, 5'h13);
        for (int i = 6; i >= 0; i--) begin
            move_to(std_l[i]);
            chk(flg, std_f[i]);
        end
        move_to(0);
        chk(flg, 5'h1C);
        i_far.pull(1);
        apb(1'b0, ADDR_LEVEL, 32'h0);
        chk(rd, 32'h0);
        chk(data_out, W0 + 18'h1FFF);

        do_reset(1'b1, 1'b1);
        apb(1'b0, ADDR_FULL_OFF, 32'h0);
        chk(rd, 32'h3FF);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd & 32'h7F, 32'h67);
        w = i_far.seq;
        i_far.push(1);
        repeat (3) @(posedge clk);
        chk({31'h0, data_out === w}, 32'h0);
        @(posedge clk);
        chk(data_out, w);
        lvl = 1;
        for (int i = 0; i < 8; i++) begin
            move_to(ft_l[i]);
            chk(flg, ft_f[i]);
        end
        i_far.push(1);
        apb(1'b0, ADDR_LEVEL, 32'h0);
        chk(rd, 32'd8193);
        move_to(8192);
        chk(flg, 5'h02);
        for (int i = 6; i >= 0; i--) begin
            move_to(ft_l[i]);
            chk(flg, ft_f[i]);
        end
        move_to(0);
        chk(flg, 5'h0D);
        shift_bits(26'h0154155, 0, 24);
        apb(1'b0, ADDR_EMPTY_OFF, 32'h0);
        chk(rd, 32'h3FF);
        shift_bits(26'h0154155, 25, 25);
        apb(1'b0, ADDR_EMPTY_OFF, 32'h0);
        chk(rd, 32'h155);
        apb(1'b0, ADDR_FULL_OFF, 32'h0);
        chk(rd, 32'hAA);
        move_to(342);
        chk(flg, 5'h0C);
        move_to(343);
        chk(flg, 5'h0E);
        ft_sel <= 1'b0;
        ld_sel_n <= 1'b0;
        repeat (4) @(posedge clk);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd & 32'h3, 32'h3);
        end_sim();
    end
endmodule // dcf_fifo_tb_top
